// >>> verilog/qdec_pkg.sv
// Constants shared by the three-axis quadrature decoder.
package qdec_pkg;

    // System clock and the highest sampling rate allowed.
    localparam int CLOCK_MHZ      = 250;
    localparam int SAMPLE_MAX_MHZ = 16;
    // Shortest sampling interval in clock cycles, rounded up.
    localparam logic [9:0] MIN_DIV =
        10'((CLOCK_MHZ + SAMPLE_MAX_MHZ - 1) / SAMPLE_MAX_MHZ);

    // Filter length in sampling periods.
    localparam int FILTER_LEN = 3;

    // Register byte offsets.
    localparam logic [7:0] DECODER_CONTROL_OFS  = 8'h00;
    localparam logic [7:0] X_STEP_COUNT_OFS     = 8'h04;
    localparam logic [7:0] Y_STEP_COUNT_OFS     = 8'h08;
    localparam logic [7:0] Z_STEP_COUNT_OFS     = 8'h0c;
    localparam logic [7:0] SAMPLE_DIVIDER_OFS   = 8'h10;
    localparam logic [7:0] AXIS_PIN_SELECT_OFS  = 8'h14;
    localparam logic [7:0] DECODER_MODE_PIN_OFS = 8'h18;
    localparam logic [7:0] TOTAL_EDGE_CNT_OFS   = 8'h1c;

    // Control register fields.
    localparam int THRESHOLD_LSB = 0;
    localparam int PENDING_BIT   = 8;
    localparam int CNT_CLEAR_BIT = 9;

    // Mode and enable register fields.
    localparam int ENABLE_LSB = 0;
    localparam int MODE_LSB   = 3;

    // Pin select fields: four bits per channel, A then B, X then Y then Z.
    localparam int PIN_SEL_W = 4;
    localparam int NUM_PINS  = 12;

    // Values after reset.
    localparam logic [9:0]  DIVIDER_RST   = 10'h010;
    localparam logic [23:0] PIN_SEL_RST   = 24'h543210;
    localparam logic [7:0]  THRESHOLD_RST = 8'h01;

endpackage : qdec_pkg

// >>> verilog/three_axis_quadrature_decoder.sv
// Three-axis quadrature decoder with APB register access.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns

module three_axis_quadrature_decoder (
    // Clock and reset.
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Pins and system controls.
    input  wire logic [11:0] GPIO_IN,
    input  wire logic        DECODER_CLOCK_ENABLE,
    input  wire logic        LOW_POWER_CLOCK_SEL,
    // Event outputs.
    output logic             EVENT_IRQ,
    output logic             WAKEUP
);

    typedef struct packed {
        logic [9:0]       div_cnt;
        logic [5:0][2:0]  hist;
        logic [5:0]       filt;
        logic [2:0][15:0] cnt;
        logic [2:0]       dir;
        logic [7:0]       evt;
        logic             pend;
        logic [7:0]       thres;
        logic [9:0]       divider;
        logic [23:0]      pinsel;
        logic [2:0]       en;
        logic [2:0]       mode;
        logic [31:0]      rdata;
    } state_t;

    state_t st;
    state_t next_st;

    logic       setup;
    logic       wr;
    logic       mapped;
    logic       tick;
    logic [5:0] raw;
    logic [5:0] edges;
    logic       any_edge;
    logic       clr_pend;
    logic       clr_evt;
    logic       evt_inc;
    logic [9:0] reload;

    // Picks one of the general-purpose pins; unused codes read low.
    function automatic logic pick(input logic [11:0] pins, input logic [3:0] sel);
        logic bit_val;
        bit_val = 1'b0;
        if (sel < 4'(qdec_pkg::NUM_PINS)) begin
            bit_val = pins[sel];
        end
        return bit_val;
    endfunction : pick

    // True when the address is one of the eight registers.
    function automatic logic is_mapped(input logic [7:0] a);
        logic hit;
        hit = (a == qdec_pkg::DECODER_CONTROL_OFS) ||
              (a == qdec_pkg::X_STEP_COUNT_OFS) ||
              (a == qdec_pkg::Y_STEP_COUNT_OFS) ||
              (a == qdec_pkg::Z_STEP_COUNT_OFS) ||
              (a == qdec_pkg::SAMPLE_DIVIDER_OFS) ||
              (a == qdec_pkg::AXIS_PIN_SELECT_OFS) ||
              (a == qdec_pkg::DECODER_MODE_PIN_OFS) ||
              (a == qdec_pkg::TOTAL_EDGE_CNT_OFS);
        return hit;
    endfunction : is_mapped

    assign setup    = PSEL && !PENABLE;
    assign wr       = PSEL && PENABLE && PWRITE;
    assign mapped   = is_mapped(PADDR);
    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL && PENABLE && !mapped;
    assign PRDATA   = st.rdata;
    assign clr_pend = wr && (PADDR == qdec_pkg::DECODER_CONTROL_OFS) &&
                      PWDATA[qdec_pkg::PENDING_BIT];
    assign clr_evt  = wr && (PADDR == qdec_pkg::DECODER_CONTROL_OFS) &&
                      PWDATA[qdec_pkg::CNT_CLEAR_BIT];

    // Divided sampling interval never drops below the 16 MHz limit.
    assign reload = (st.divider < qdec_pkg::MIN_DIV) ?
                    qdec_pkg::MIN_DIV - 10'h001 : st.divider - 10'h001;

    // Low-power clock samples on every cycle.
    assign tick = DECODER_CLOCK_ENABLE &&
                  (LOW_POWER_CLOCK_SEL || (st.div_cnt == 10'h000));

    // Channel order: X A, X B, Y A, Y B, Z A, Z B.
    always_comb begin
        for (int c = 0; c < 6; c++) begin
            raw[c] = pick(GPIO_IN, st.pinsel[c*4 +: 4]);
        end
    end

    always_comb begin
        logic [2:0] h;
        logic       ea;
        logic       eb;
        logic       up;
        h       = 3'h0;
        ea      = 1'b0;
        eb      = 1'b0;
        up      = 1'b0;
        next_st = st;
        edges   = 6'h00;

        // Sampling divider.
        if (!DECODER_CLOCK_ENABLE || LOW_POWER_CLOCK_SEL) begin
            next_st.div_cnt = reload;
        end else if (st.div_cnt == 10'h000) begin
            next_st.div_cnt = reload;
        end else begin
            next_st.div_cnt = st.div_cnt - 10'h001;
        end

        // Filter: output follows only three equal samples in a row.
        for (int c = 0; c < 6; c++) begin
            h = {st.hist[c][1:0], raw[c]};
            if (tick) begin
                next_st.hist[c] = h;
                if ((h == 3'h7 && !st.filt[c]) || (h == 3'h0 && st.filt[c])) begin
                    next_st.filt[c] = h[0];
                    edges[c]        = 1'b1;
                end
            end
        end
        any_edge = 1'b0;

        // Axis decoding.
        for (int i = 0; i < 3; i++) begin
            ea = edges[2*i];
            eb = edges[2*i+1];
            if (!st.en[i]) begin
                next_st.cnt[i] = 16'h0000;
            end else if (ea || eb) begin
                any_edge = 1'b1;
                if (st.mode[i]) begin
                    next_st.cnt[i] = st.cnt[i] + 16'h0001;
                end else begin
                    if (ea && eb) begin
                        up = st.dir[i];
                    end else if (ea) begin
                        up = next_st.filt[2*i] ^ next_st.filt[2*i+1];
                    end else begin
                        up = ~(next_st.filt[2*i] ^ next_st.filt[2*i+1]);
                    end
                    next_st.dir[i] = up;
                    next_st.cnt[i] = up ? st.cnt[i] + 16'h0001 :
                                          st.cnt[i] - 16'h0001;
                end
            end
        end

        // Event counter: one count per sample with an edge on an enabled axis; a clear in an edge cycle restarts it at one.
        if (clr_evt) begin
            next_st.evt = {7'h00, any_edge};
        end else if (any_edge) begin
            next_st.evt = st.evt + 8'h01;
        end
        evt_inc = any_edge;

        // Pending flag: a threshold hit in the clearing cycle wins.
        if (any_edge && next_st.evt == st.thres) begin
            next_st.pend = 1'b1;
        end else if (clr_pend) begin
            next_st.pend = 1'b0;
        end

        // Register writes.
        if (wr) begin
            if (PADDR == qdec_pkg::DECODER_CONTROL_OFS) begin
                next_st.thres = PWDATA[qdec_pkg::THRESHOLD_LSB +: 8];
            end else if (PADDR == qdec_pkg::SAMPLE_DIVIDER_OFS) begin
                next_st.divider = PWDATA[9:0];
            end else if (PADDR == qdec_pkg::AXIS_PIN_SELECT_OFS) begin
                next_st.pinsel = PWDATA[23:0];
            end else if (PADDR == qdec_pkg::DECODER_MODE_PIN_OFS) begin
                next_st.en   = PWDATA[qdec_pkg::ENABLE_LSB +: 3];
                next_st.mode = PWDATA[qdec_pkg::MODE_LSB +: 3];
            end
        end

        // Read data is captured in the setup cycle.
        if (setup) begin
            if (PADDR == qdec_pkg::DECODER_CONTROL_OFS) begin
                next_st.rdata = {22'h000000, 1'b0, st.pend, st.thres};
            end else if (PADDR == qdec_pkg::X_STEP_COUNT_OFS) begin
                next_st.rdata = {{16{st.cnt[0][15]}}, st.cnt[0]};
            end else if (PADDR == qdec_pkg::Y_STEP_COUNT_OFS) begin
                next_st.rdata = {{16{st.cnt[1][15]}}, st.cnt[1]};
            end else if (PADDR == qdec_pkg::Z_STEP_COUNT_OFS) begin
                next_st.rdata = {{16{st.cnt[2][15]}}, st.cnt[2]};
            end else if (PADDR == qdec_pkg::SAMPLE_DIVIDER_OFS) begin
                next_st.rdata = {22'h000000, st.divider};
            end else if (PADDR == qdec_pkg::AXIS_PIN_SELECT_OFS) begin
                next_st.rdata = {8'h00, st.pinsel};
            end else if (PADDR == qdec_pkg::DECODER_MODE_PIN_OFS) begin
                next_st.rdata = {26'h0000000, st.mode, st.en};
            end else if (PADDR == qdec_pkg::TOTAL_EDGE_CNT_OFS) begin
                next_st.rdata = {24'h000000, st.evt};
            end else begin
                next_st.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            st         <= '0;
            st.div_cnt <= qdec_pkg::DIVIDER_RST - 10'h001;
            st.divider <= qdec_pkg::DIVIDER_RST;
            st.pinsel  <= qdec_pkg::PIN_SEL_RST;
            st.thres   <= qdec_pkg::THRESHOLD_RST;
        end else begin
            st <= next_st;
        end
    end

    assign EVENT_IRQ = st.pend;
    assign WAKEUP    = st.pend;

    // Checks.
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    sequence quiet_gap;
        !tick [*8];
    endsequence

    sequence threshold_hit;
        evt_inc && (next_st.evt == st.thres);
    endsequence

    sequence x_a_leads;
        st.en[0] && !st.mode[0] && edges[0] && !edges[1] && !st.filt[0] && !st.filt[1];
    endsequence

    sequence x_b_leads;
        st.en[0] && !st.mode[0] && edges[1] && !edges[0] && !st.filt[0] && !st.filt[1];
    endsequence

    AST_TICK_GAP: assert property (
        (tick && !LOW_POWER_CLOCK_SEL && $past(!LOW_POWER_CLOCK_SEL)
         && !$past(!DECODER_CLOCK_ENABLE)) |=> (quiet_gap or LOW_POWER_CLOCK_SEL))
        else $error("Sampling faster than allowed.");

    AST_ONE_STEP: assert property (
        (st.en[0] && $past(st.en[0])) |->
            ((st.cnt[0] - $past(st.cnt[0])) inside {16'h0000, 16'h0001, 16'hffff}))
        else $error("Axis counter moved by more than one.");

    AST_DISABLE_CLEAR: assert property (
        !st.en[1] |=> (st.cnt[1] == 16'h0000))
        else $error("Disabled axis counter not zero.");

    AST_FILTER_ON_TICK: assert property (
        $changed(st.filt) |-> $past(tick))
        else $error("Filtered level changed without a sample.");

    AST_IRQ_SET: assert property (
        threshold_hit |=> (EVENT_IRQ && st.evt == $past(st.thres)))
        else $error("Threshold match did not raise the interrupt.");

    AST_IRQ_HOLD: assert property (
        (EVENT_IRQ && !clr_pend) |=> EVENT_IRQ)
        else $error("Pending interrupt dropped without a clear.");

    AST_IRQ_CLEAR: assert property (
        (clr_pend && !threshold_hit) |=> !EVENT_IRQ)
        else $error("Interrupt clear was ignored.");

    AST_EVT_CLEAR: assert property (
        (clr_evt && !evt_inc) |=> (st.evt == 8'h00))
        else $error("Event counter not cleared.");

    AST_GATED: assert property (
        (!DECODER_CLOCK_ENABLE && !clr_evt) |=> $stable(st.evt))
        else $error("Event counter moved while the decoder was off.");

    AST_WAKE: assert property (
        WAKEUP == EVENT_IRQ)
        else $error("Wake-up output differs from interrupt.");

    AST_QUAD_UP: assert property (
        x_a_leads |=> (st.cnt[0] == $past(st.cnt[0]) + 16'h0001))
        else $error("Channel A leading did not count up.");

    AST_QUAD_DOWN: assert property (
        x_b_leads |=> (st.cnt[0] == $past(st.cnt[0]) - 16'h0001))
        else $error("Channel B leading did not count down.");

    AST_COINCIDENT: assert property (
        (st.en[0] && edges[0] && edges[1]) |=>
            ((st.cnt[0] - $past(st.cnt[0])) inside {16'h0001, 16'hffff}))
        else $error("Coincident edges did not move the counter by one.");

    AST_EDGE_MODE: assert property (
        (st.en[1] && st.mode[1] && (edges[2] || edges[3])) |=>
            (st.cnt[1] == $past(st.cnt[1]) + 16'h0001))
        else $error("Edge mode did not count the edge.");

    AST_EVT_ONCE: assert property (
        (evt_inc && !clr_evt) |=> (st.evt == $past(st.evt) + 8'h01))
        else $error("Event counter did not step by one.");

    AST_EVT_IDLE: assert property (
        (!evt_inc && !clr_evt) |=> $stable(st.evt))
        else $error("Event counter moved without an edge.");

    AST_LP_EVERY: assert property (
        (LOW_POWER_CLOCK_SEL && DECODER_CLOCK_ENABLE) |=> (st.hist[0][0] == $past(raw[0])))
        else $error("Low-power clock did not sample every cycle.");

    AST_PIN_UNUSED: assert property (
        (st.pinsel[19:16] >= 4'hc) |-> !raw[4])
        else $error("Unused pin code did not read low.");

    AST_HOLD_OFF: assert property (
        !DECODER_CLOCK_ENABLE |=> ($stable(st.filt) && $stable(st.hist)))
        else $error("Channels sampled while the decoder was off.");

    AST_READ_SIGN: assert property (
        (PSEL && PENABLE && !PWRITE && (PADDR == qdec_pkg::X_STEP_COUNT_OFS)) |->
            (PRDATA[31:16] == {16{PRDATA[15]}}))
        else $error("Axis count read without sign extension.");

    AST_FILTER_RISE: assert property (
        $rose(st.filt[0]) |-> (st.hist[0] == 3'h7))
        else $error("Filter rose without three high samples.");

    AST_FILTER_FALL: assert property (
        $fell(st.filt[0]) |-> (st.hist[0] == 3'h0))
        else $error("Filter fell without three low samples.");

    AST_THRES_ONLY: assert property (
        $rose(EVENT_IRQ) |-> ($past(evt_inc) && (st.evt == $past(st.thres))))
        else $error("Interrupt rose away from the threshold.");

    AST_WRITE_THRES: assert property (
        (wr && (PADDR == qdec_pkg::DECODER_CONTROL_OFS)) |=> (st.thres == $past(PWDATA[7:0])))
        else $error("Threshold write did not land.");

    AST_DISABLE_Z: assert property (
        !st.en[2] |=> (st.cnt[2] == 16'h0000))
        else $error("Disabled Z counter not zero.");

endmodule : three_axis_quadrature_decoder

// >>> sim/qdec_encoder_model.sv
// Behavioural quadrature encoder that drives the general-purpose pins.
`timescale 1ns/1ns

module qdec_encoder_model (
    // Clock.
    input  wire logic        clk,
    // Pin levels.
    output logic      [11:0] pins
);
    initial begin
        pins = 12'h000;
    end

    // Moves one axis by n edges; forward has channel a leading.
    task automatic step(input int a, input int b, input bit fwd, input int n,
                        input int hold);
        repeat (n) begin
            @(posedge clk);
            if ((pins[a] == pins[b]) == fwd) begin
                pins[a] <= ~pins[a];
            end else begin
                pins[b] <= ~pins[b];
            end
            repeat (hold) @(posedge clk);
        end
    endtask : step

    // Spike on one pin that lasts width cycles.
    task automatic pulse(input int a, input int width);
        @(posedge clk);
        pins[a] <= ~pins[a];
        repeat (width) @(posedge clk);
        pins[a] <= ~pins[a];
        repeat (8) @(posedge clk);
    endtask : pulse

    // Both channels of a pair change on the same edge.
    task automatic both(input int a, input int b, input int hold);
        @(posedge clk);
        pins[a] <= ~pins[a];
        pins[b] <= ~pins[b];
        repeat (hold) @(posedge clk);
    endtask : both
endmodule : qdec_encoder_model

// >>> sim/tb.sv
// Self-checking testbench for the three-axis quadrature decoder.
`timescale 1ns/1ns

module tb;
    localparam logic [7:0] CTRL = qdec_pkg::DECODER_CONTROL_OFS;
    localparam logic [7:0] XCNT = qdec_pkg::X_STEP_COUNT_OFS;
    localparam logic [7:0] YCNT = qdec_pkg::Y_STEP_COUNT_OFS;
    localparam logic [7:0] ZCNT = qdec_pkg::Z_STEP_COUNT_OFS;
    localparam logic [7:0] DIV  = qdec_pkg::SAMPLE_DIVIDER_OFS;
    localparam logic [7:0] PINS = qdec_pkg::AXIS_PIN_SELECT_OFS;
    localparam logic [7:0] MODE = qdec_pkg::DECODER_MODE_PIN_OFS;
    localparam logic [7:0] TOT  = qdec_pkg::TOTAL_EDGE_CNT_OFS;

    logic        clock;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] pins;
    logic        dec_en;
    logic        lp_sel;
    logic        irq;
    logic        wakeup;
    logic [31:0] rdata;
    logic        last_err;
    int          n_fail;
    int          checks_done;

    three_axis_quadrature_decoder i_three_axis_quadrature_decoder (
        .CLOCK(clock), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .GPIO_IN(pins),
        .DECODER_CLOCK_ENABLE(dec_en), .LOW_POWER_CLOCK_SEL(lp_sel),
        .EVENT_IRQ(irq), .WAKEUP(wakeup)
    );

    qdec_encoder_model i_qdec_encoder_model (
        .clk(clock),
        .pins(pins)
    );

    always #2 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdata    = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rdata, exp);
    endtask : rd

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        dec_en = 1'b1;
        lp_sel = 1'b1;
        n_fail = 0;
        checks_done = 0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        rd(CTRL, 32'h0000_0001);
        rd(DIV, 32'h0000_0010);
        rd(PINS, 32'h0054_3210);
        rd(XCNT, 32'h0000_0000);
        rd(TOT, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        check({31'h0, last_err}, 32'h1);
        wr(CTRL, 32'h0000_0005);
        wr(MODE, 32'h0000_0001);
        i_qdec_encoder_model.step(0, 1, 1'b1, 5, 8);
        rd(XCNT, 32'h0000_0005);
        check({31'h0, irq}, 32'h1);
        check({31'h0, wakeup}, 32'h1);
        i_qdec_encoder_model.step(0, 1, 1'b0, 7, 8);
        rd(XCNT, 32'hffff_fffe);
        rd(TOT, 32'h0000_000c);
        rd(CTRL, 32'h0000_0105);
        wr(CTRL, 32'h0000_0105);
        rd(CTRL, 32'h0000_0005);
        check({31'h0, irq}, 32'h0);
        wr(CTRL, 32'h0000_0205);
        rd(TOT, 32'h0000_0000);
        i_qdec_encoder_model.pulse(0, 2);
        rd(XCNT, 32'hffff_fffe);
        dec_en <= 1'b0;
        i_qdec_encoder_model.step(0, 1, 1'b1, 2, 8);
        i_qdec_encoder_model.step(0, 1, 1'b0, 2, 8);
        dec_en <= 1'b1;
        rd(XCNT, 32'hffff_fffe);
        rd(TOT, 32'h0000_0000);
        wr(MODE, 32'h0000_0000);
        rd(XCNT, 32'h0000_0000);
        wr(PINS, 32'h0054_9810);
        wr(MODE, 32'h0000_0012);
        i_qdec_encoder_model.step(8, 9, 1'b1, 3, 8);
        i_qdec_encoder_model.step(8, 9, 1'b0, 1, 8);
        rd(YCNT, 32'h0000_0004);
        i_qdec_encoder_model.both(8, 9, 8);
        rd(YCNT, 32'h0000_0005);
        rd(TOT, 32'h0000_0005);
        check({31'h0, irq}, 32'h1);
        lp_sel <= 1'b0;
        wr(DIV, 32'h0000_0020);
        wr(MODE, 32'h0000_0013);
        // Two sample ticks only, so the filter must reject it.
        i_qdec_encoder_model.pulse(0, 64);
        rd(TOT, 32'h0000_0005);
        i_qdec_encoder_model.step(0, 1, 1'b1, 2, 160);
        rd(XCNT, 32'h0000_0002);
        rd(TOT, 32'h0000_0007);
        check({31'h0, last_err}, 32'h0);
        i_qdec_encoder_model.both(0, 1, 160);
        rd(XCNT, 32'h0000_0003);
        rd(TOT, 32'h0000_0008);
        wr(PINS, 32'h00ba_9810);
        wr(MODE, 32'h0000_0004);
        rd(XCNT, 32'h0000_0000);
        i_qdec_encoder_model.step(10, 11, 1'b0, 3, 160);
        rd(ZCNT, 32'hffff_fffd);
        // Unused select codes read low, so channel A of Z sees a falling edge.
        wr(PINS, 32'h00fc_9810);
        repeat (160) @(posedge clock);
        rd(ZCNT, 32'hffff_fffc);
        rd(TOT, 32'h0000_000c);
        summarize();
    end
endmodule : tb
